// ==== hdl/uv_irq_consts.vh ====
// Register map, field positions, reset values and timing counts of the UV index
// interrupt, threshold, status and output block. Definitions only.
`ifndef UV_IRQ_CONSTS_VH
`define UV_IRQ_CONSTS_VH

// Register addresses (7-bit serial register address).
`define ADDR_CTRL1        7'h20
`define ADDR_CTRL2        7'h21
`define ADDR_CTRL3        7'h22
`define ADDR_IRQ_SETUP    7'h23
`define ADDR_EVENT_FLAGS  7'h24
`define ADDR_THRESHOLD    7'h25
`define ADDR_STATUS       7'h27
`define ADDR_RESULT       7'h28

// Reset values.
`define RST_REG8          8'h00

// Control register 1 fields.
`define CTRL1_RATE_BIT    0
// Control register 2 fields.
`define CTRL2_SHOT_BIT    0
// Control register 3 fields.
`define CTRL3_SEL_LO      0
`define CTRL3_SEL_HI      1
`define CTRL3_OD_BIT      6
`define CTRL3_POL_BIT     7
// Interrupt setup fields.
`define SETUP_HIGH_EN_BIT 0
`define SETUP_LOW_EN_BIT  1
`define SETUP_LATCH_BIT   2
`define SETUP_GEN_EN_BIT  3
// Event flag fields.
`define FLAG_HIGH_BIT     0
`define FLAG_LOW_BIT      1
`define FLAG_ACTIVE_BIT   2
// Status fields.
`define STATUS_AVAIL_BIT  0

// Pin source select codes.
`define SEL_DATA_READY    2'h0
`define SEL_HIGH          2'h1
`define SEL_LOW           2'h2
`define SEL_HIGH_OR_LOW   2'h3

// Timing: sample period in ms and clock frequency in Hz.
`define SAMPLE_PERIOD_MS  1000
`define MCLK_HZ           25000000
`define SAMPLE_PERIOD_CYC ((`MCLK_HZ / 1000) * `SAMPLE_PERIOD_MS)

`endif

// ==== hdl/sample_tick.v ====
// Divider that issues a one-cycle enable pulse once per sample period.
// Assumes mclk is the single block clock; the count runs only while enabled.
`timescale 1ns/1ps
module sample_tick #(
	parameter PERIOD_CYC = 25000000
) (
	// Clock and reset
	input  wire mclk,
	input  wire reset_n,
	// Control
	input  wire enable,
	// Pulse
	output reg  tick
);
	reg [31:0] count_q;

	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			count_q <= 32'h00000000;
			tick    <= 1'b0;
		end else if (!enable) begin
			count_q <= 32'h00000000;
			tick    <= 1'b0;
		end else if (count_q == PERIOD_CYC - 1) begin
			count_q <= 32'h00000000;
			tick    <= 1'b1;
		end else begin
			count_q <= count_q + 32'h00000001;
			tick    <= 1'b0;
		end
	end
endmodule

// ==== hdl/uv_irq_regs.v ====
// Interrupt, threshold, status and output registers of a UV index sensor.
// Assumes the serial interface decodes accesses into one-cycle read and write
// strobes on mclk, and the measurement path returns a sample with a valid pulse.
// Function
// [R1] Threshold interrupts exist only while the generation enable bit is set.
// [R2] With latch set, event flags hold until read; otherwise they follow the condition.
// [R3] With low enable set, a sample below the threshold raises a low request.
// [R4] With high enable set, a sample above the threshold raises a high request.
// [R5] Bit 2 of the event flags shows that one or more events were generated.
// [R6] Bit 1 of the event flags shows a low event, reset 0.
// [R7] Bit 0 of the event flags shows a high event, reset 0.
// [R8] The host-written 8-bit threshold serves both comparisons.
// [R9] Status bit 0 is set each time a new sample is available.
// [R10] Reading the result register clears the data-available flag.
// [R11] The measured UV index is readable as an 8-bit result register.
// [R12] The host writes zero to every fixed-zero configuration bit.
// [R13] A 2-bit select routes data ready, high, low or either to the pin.
// [R14] The pin is active high when the polarity bit is 0, active low when 1.
// [R15] Rate bit 1 samples continuously at 1 Hz; 0 selects one-shot mode.
// [R16] Writing 1 to the shot bit takes one sample, then the bit self-clears.
// [R17] The active flag is the OR of the event flags; a read clears latched flags.
`timescale 1ns/1ps
`include "uv_irq_consts.vh"
module uv_irq_regs #(
	parameter SAMPLE_PERIOD_CYC = `SAMPLE_PERIOD_CYC
) (
	// Clock and reset
	input  wire       mclk,
	input  wire       reset_n,
	// Register access from the serial interface
	input  wire [6:0] reg_addr,
	input  wire       reg_wr,
	input  wire [7:0] reg_wdata,
	input  wire       reg_rd,
	output reg  [7:0] reg_rdata,
	// Measurement path
	output reg        sample_start,
	input  wire       sample_valid,
	input  wire [7:0] sample_value,
	// Interrupt pin
	output reg        irq_pin,
	output reg        irq_pin_oe
);
	reg [7:0] ctrl1_q;
	reg [7:0] ctrl2_q;
	reg [7:0] ctrl3_q;
	reg [7:0] irq_setup_q;
	reg [7:0] threshold_value_q;
	reg       high_event_flag_q;
	reg       low_event_flag_q;
	reg       sample_available_flag_q;
	reg [7:0] uv_index_result_q;
	reg       busy_q;
	wire      tick;

	wire continuous_rate_enable = ctrl1_q[`CTRL1_RATE_BIT];
	wire one_shot_req           = ctrl2_q[`CTRL2_SHOT_BIT];
	wire irq_generation_enable  = irq_setup_q[`SETUP_GEN_EN_BIT];
	wire irq_latch_select       = irq_setup_q[`SETUP_LATCH_BIT];
	wire low_event_enable       = irq_setup_q[`SETUP_LOW_EN_BIT];
	wire high_event_enable      = irq_setup_q[`SETUP_HIGH_EN_BIT];
	wire [1:0] pin_sel          = ctrl3_q[`CTRL3_SEL_HI:`CTRL3_SEL_LO];
	wire pin_low_active         = ctrl3_q[`CTRL3_POL_BIT];
	wire pin_open_drain         = ctrl3_q[`CTRL3_OD_BIT];

	wire wr_ctrl1  = reg_wr && (reg_addr == `ADDR_CTRL1);
	wire wr_ctrl2  = reg_wr && (reg_addr == `ADDR_CTRL2);
	wire wr_ctrl3  = reg_wr && (reg_addr == `ADDR_CTRL3);
	wire wr_setup  = reg_wr && (reg_addr == `ADDR_IRQ_SETUP);
	wire wr_thresh = reg_wr && (reg_addr == `ADDR_THRESHOLD);
	wire rd_flags  = reg_rd && (reg_addr == `ADDR_EVENT_FLAGS);
	wire rd_result = reg_rd && (reg_addr == `ADDR_RESULT);

	// Comparisons against the sample arriving now.
	wire gen_ok   = irq_generation_enable; // [R1]
	wire high_now = gen_ok && high_event_enable && (sample_value > threshold_value_q); // [R4] [R8]
	wire low_now  = gen_ok && low_event_enable && (sample_value < threshold_value_q); // [R3] [R8]
	wire irq_active_flag = high_event_flag_q | low_event_flag_q; // [R5] [R17]

	sample_tick #(
		.PERIOD_CYC (SAMPLE_PERIOD_CYC)
	) u_tick (
		.mclk    (mclk),
		.reset_n (reset_n),
		.enable  (continuous_rate_enable),
		.tick    (tick)
	);

	// Configuration registers; fixed-zero bits are stored as written.
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl1_q           <= `RST_REG8;
			ctrl3_q           <= `RST_REG8;
			irq_setup_q       <= `RST_REG8;
			threshold_value_q <= `RST_REG8;
		end else begin
			if (wr_ctrl1)
				ctrl1_q <= reg_wdata;
			if (wr_ctrl3)
				ctrl3_q <= reg_wdata;
			if (wr_setup)
				irq_setup_q <= reg_wdata;
			if (wr_thresh)
				threshold_value_q <= reg_wdata; // [R8]
		end
	end

	// Sample sequencing: periodic in continuous mode, single in one-shot mode.
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl2_q      <= `RST_REG8;
			busy_q       <= 1'b0;
			sample_start <= 1'b0;
		end else begin
			sample_start <= 1'b0;
			if (wr_ctrl2)
				ctrl2_q <= reg_wdata;
			if (sample_valid) begin
				busy_q <= 1'b0;
				if (!wr_ctrl2)
					ctrl2_q[`CTRL2_SHOT_BIT] <= 1'b0; // [R16]
			end else if (!busy_q && continuous_rate_enable && tick) begin
				busy_q       <= 1'b1; // [R15]
				sample_start <= 1'b1;
			end else if (!busy_q && !continuous_rate_enable && one_shot_req) begin
				busy_q       <= 1'b1; // [R16]
				sample_start <= 1'b1;
			end
		end
	end

	// Result, data-available and event flags.
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			uv_index_result_q       <= `RST_REG8;
			sample_available_flag_q <= 1'b0;
			high_event_flag_q       <= 1'b0;
			low_event_flag_q        <= 1'b0;
		end else begin
			if (sample_valid)
				uv_index_result_q <= sample_value; // [R11]
			if (sample_valid)
				sample_available_flag_q <= 1'b1; // [R9]
			else if (rd_result)
				sample_available_flag_q <= 1'b0; // [R10]
			if (!gen_ok) begin
				high_event_flag_q <= 1'b0; // [R1]
				low_event_flag_q  <= 1'b0;
			end else if (irq_latch_select) begin
				if (sample_valid && high_now)
					high_event_flag_q <= 1'b1; // [R2] [R7]
				else if (rd_flags)
					high_event_flag_q <= 1'b0; // [R17]
				if (sample_valid && low_now)
					low_event_flag_q <= 1'b1; // [R2] [R6]
				else if (rd_flags)
					low_event_flag_q <= 1'b0; // [R17]
			end else if (sample_valid) begin
				high_event_flag_q <= high_now; // [R2] [R7]
				low_event_flag_q  <= low_now; // [R2] [R6]
			end
		end
	end

	// Read data, registered one cycle after the read strobe.
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= `RST_REG8;
		end else if (reg_rd) begin
			case (reg_addr)
				`ADDR_CTRL1:       reg_rdata <= ctrl1_q;
				`ADDR_CTRL2:       reg_rdata <= ctrl2_q;
				`ADDR_CTRL3:       reg_rdata <= ctrl3_q;
				`ADDR_IRQ_SETUP:   reg_rdata <= irq_setup_q;
				`ADDR_EVENT_FLAGS: reg_rdata <= {5'h00, irq_active_flag, low_event_flag_q,
					high_event_flag_q}; // [R5]
				`ADDR_THRESHOLD:   reg_rdata <= threshold_value_q;
				`ADDR_STATUS:      reg_rdata <= {7'h00, sample_available_flag_q};
				`ADDR_RESULT:      reg_rdata <= uv_index_result_q; // [R11]
				default:           reg_rdata <= 8'h00;
			endcase
		end
	end

	// Interrupt pin source, polarity and drive mode.
	reg pin_src;
	always @* begin
		case (pin_sel)
			`SEL_DATA_READY: pin_src = sample_available_flag_q; // [R13]
			`SEL_HIGH:       pin_src = high_event_flag_q;
			`SEL_LOW:        pin_src = low_event_flag_q;
			default:         pin_src = irq_active_flag;
		endcase
	end

	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			irq_pin    <= 1'b0;
			irq_pin_oe <= 1'b1;
		end else begin
			irq_pin    <= pin_src ^ pin_low_active; // [R14]
			irq_pin_oe <= pin_open_drain ? (pin_src ^ pin_low_active) == 1'b0 : 1'b1;
		end
	end
endmodule

// ==== dv/meas_model.sv ====
// Measurement path model: answers each start pulse with one valid pulse.
// Assumes a one-cycle start pulse on mclk and a delay of at least 1.
`timescale 1ns/1ps
module meas_model (
	// Clock and reset
	input  logic       mclk,
	input  logic       reset_n,
	// Handshake
	input  logic       sample_start,
	input  int         delay,
	input  logic [7:0] value,
	output logic       sample_valid,
	output logic [7:0] sample_value
);
	int wait_q;
	// Outside the valid pulse the data toggles, so a stale value never passes.
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			wait_q <= 0;
			sample_valid <= 1'b0;
			sample_value <= 8'h00;
		end else begin
			sample_valid <= wait_q == 1;
			sample_value <= (wait_q == 1) ? value : ~sample_value;
			wait_q <= sample_start ? delay : (wait_q > 0 ? wait_q - 1 : 0);
		end
	end
endmodule

// ==== dv/uv_irq_regs_assertions.sv ====
// Checker of the UV index register block.
// Sees only the block's ports; mirrors setup, threshold and the last sample.
`timescale 1ns/1ps
module uv_irq_regs_assertions (
	// Clock and reset
	input logic       mclk,
	input logic       reset_n,
	// Register access
	input logic [6:0] reg_addr,
	input logic       reg_wr,
	input logic [7:0] reg_wdata,
	input logic       reg_rd,
	input logic [7:0] reg_rdata,
	// Measurement and pin
	input logic       sample_start,
	input logic       sample_valid,
	input logic [7:0] sample_value,
	input logic       irq_pin,
	input logic       irq_pin_oe
);
	logic [7:0] setup_q, thr_q, last_q;
	logic [2:0] exp_q;
	logic       da_q;
	wire        rd24 = reg_rd && reg_addr == 7'h24 && !sample_valid;
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			setup_q <= 8'h00;
			thr_q <= 8'h00;
			last_q <= 8'h00;
			exp_q <= 3'h0;
			da_q <= 1'b0;
		end else if (sample_valid) begin
			last_q <= sample_value;
			da_q <= 1'b1;
			exp_q <= {setup_q[2], setup_q[3] && setup_q[1] && sample_value < thr_q,
				setup_q[3] && setup_q[0] && sample_value > thr_q};
		end else begin
			if (reg_wr && reg_addr == 7'h23)
				setup_q <= reg_wdata;
			if (reg_wr && reg_addr == 7'h25)
				thr_q <= reg_wdata;
			if (reg_wr && reg_addr == 7'h23 && !reg_wdata[3])
				exp_q <= 3'h0;
			if (reg_rd && reg_addr == 7'h28)
				da_q <= 1'b0;
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	sequence latched_reread;
		rd24 && setup_q[2] ##1 !sample_valid ##1 rd24;
	endsequence
	chk_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved");
	chk_start_pulse: assert property (sample_start |=> !sample_start)
		else $error("start pulse too long");
	chk_result_read: assert property (reg_rd && reg_addr == 7'h28 && !sample_valid
		|=> reg_rdata == last_q) else $error("bad result");
	chk_status_flag: assert property (reg_rd && reg_addr == 7'h27 && !sample_valid
		|=> reg_rdata == {7'h00, da_q}) else $error("bad status");
	chk_active_or: assert property (reg_rd && reg_addr == 7'h24
		|=> reg_rdata[7:2] == {5'h00, |reg_rdata[1:0]}) else $error("bad active flag");
	chk_event_flags: assert property (rd24 && !exp_q[2]
		|=> reg_rdata[1:0] == exp_q[1:0]) else $error("bad event flags");
	chk_latch_clear: assert property (latched_reread |=> reg_rdata[2:0] == 3'h0)
		else $error("latched flags not cleared");
	chk_oe_drain: assert property (!irq_pin_oe |-> irq_pin)
		else $error("pin released while low");
endmodule
bind uv_irq_regs uv_irq_regs_assertions i_chk (.*);

// ==== dv/tb_top.sv ====
// Self-checking bench for uv_irq_regs against a bench model of its registers.
// Assumes meas_model on the measurement side and the bound checker.
`timescale 1ns/1ps
module tb_top;
	logic mclk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, da = 0, src, pin;
	logic [6:0] reg_addr = 0;
	logic [7:0] reg_wdata = 0, value = 0, res = 0, reg_rdata, sample_value;
	logic sample_start, sample_valid, irq_pin, irq_pin_oe;
	logic [7:0] rm [32:40] = '{default: 8'h00};
	logic [1:0] flags = 0, nf;
	int delay = 1, seed = 25, bad_count = 0, checks_done = 0, cycles = 0, i, n;
	always #20 mclk = ~mclk;
	uv_irq_regs #(.SAMPLE_PERIOD_CYC(20)) i_dut (.*);
	meas_model i_meas (.*);
	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task finish_test;
		if (bad_count == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		if (a inside {7'h20, 7'h21, 7'h22, 7'h23, 7'h25})
			rm[a] = d;
		if (a == 7'h23 && !d[3])
			flags = 2'h0;
	endtask
	task rd(input logic [6:0] a);
		logic [7:0] e;
		case (a)
			7'h24: e = {5'h00, |flags, flags};
			7'h27: e = {7'h00, da};
			7'h28: e = res;
			7'h20, 7'h21, 7'h22, 7'h23, 7'h25: e = rm[a];
			default: e = 8'h00;
		endcase
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(negedge mclk);
		chk("reg_rdata", e, reg_rdata);
		if (a == 7'h24 && rm[35][2])
			flags = 2'h0;
		if (a == 7'h28)
			da = 1'b0;
	endtask
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 5000) begin
			bad_count++;
			finish_test;
		end
	end
	initial begin
		repeat (10) @(posedge mclk);
		reset_n <= 1'b1;
		for (i = 36; i <= 40; i++)
			wr(7'(i), 8'hFF);
		for (i = 32; i <= 40; i++)
			rd(7'(i));
		for (n = 0; n < 16; n++) begin
			value = 8'($random(seed));
			delay = 1 + ($random(seed) & 3);
			wr(7'h25, 8'($random(seed)));
			wr(7'h23, 8'($random(seed)) & 8'h0F);
			wr(7'h22, 8'($random(seed)) & 8'hC3);
			wr(7'h21, 8'h01);
			for (i = 0; i < 20 && !sample_valid; i++)
				@(negedge mclk);
			chk("sample_valid", 8'h01, {7'h00, sample_valid});
			nf = {rm[35][3] && rm[35][1] && value < rm[37],
				rm[35][3] && rm[35][0] && value > rm[37]};
			flags = rm[35][2] ? flags | nf : nf;
			da = 1'b1;
			res = value;
			rm[33] = 8'h00;
			repeat (3) @(negedge mclk);
			src = rm[34][1:0] == 2'h0 ? da : |(flags & rm[34][1:0]);
			pin = src ^ rm[34][7];
			chk("irq_pin", {6'h00, pin, rm[34][6] ? !pin : 1'b1}, {6'h00, irq_pin, irq_pin_oe});
			rd(7'h21);
			rd(7'h24);
			rd(7'h24);
			rd(7'h27);
			rd(7'h28);
			rd(7'h27);
		end
		wr(7'h20, 8'h01);
		@(posedge sample_start);
		n = cycles;
		@(posedge sample_start);
		chk("start_gap", 8'h14, 8'(cycles - n));
		finish_test;
	end
endmodule
